// [hdl/system_tick_value_calib.sv]
`timescale 1ns/1ps
`include "tick_defines.svh"
module system_tick_value_calib #(
   parameter logic [31:0] BASE_ADDR = `TICK_BASE_ADDR,
   parameter tick_pkg::count_type CALIB_COUNT = `TICK_CALIB_COUNT_RESET
)
(
   input wire logic mclk_in, // Processor clock, 25 MHz
   input wire logic reset_n_in, // Async reset, active low
   input wire logic psel_in, // APB select
   input wire logic penable_in, // APB access phase
   input wire logic pwrite_in, // APB direction, 1 is write
   input wire logic [31:0] paddr_in, // APB byte address
   input wire logic [31:0] pwdata_in, // APB write data
   input wire logic clock_stop_in, // Low-power clock gate active
   input wire logic debug_halt_in, // Processor halted for debug
   output logic [31:0] prdata_out, // APB read data
   output logic pready_out, // APB ready
   output logic pslverr_out, // APB error, unmapped or misaligned
   output logic tick_request_out, // Tick exception request pulse
   output tick_pkg::count_type count_out // Live count
);
   import tick_pkg::*;

   // ==========================================================
   // Declarations
   tick_ref_if ref_if ();

   logic pready_reg;
   logic pready_next;
   logic [31:0] prdata_reg;
   logic [31:0] prdata_next;
   logic pslverr_reg;
   logic pslverr_next;
   logic enable_reg;
   logic tick_interrupt_enable_reg;
   logic clksrc_reg;
   logic flag_reg;
   logic flag_next;
   logic flag_returned_reg;
   count_type reload_reg;
   count_type value_reg;
   count_type value_next;
   logic request_reg;
   logic access;
   logic capture;
   logic done;
   logic bad_addr;
   logic wr_ctrl;
   logic wr_reload;
   logic wr_value;
   logic rd_ctrl;
   logic count_tick;
   logic reach_zero;
   reg_sel_type sel;

   // Control reset word, named so single bits can be taken from it
   localparam logic [31:0] CTRL_RESET = `TICK_CTRL_RESET;

   // ==========================================================
   // Address decode
   // Full address compare keeps aliases out of the map
   function automatic reg_sel_type decode(input logic [31:0] addr);
      reg_sel_type s;
      s = SEL_NONE;
      if (addr[1:0] == 2'h0 && addr[31:4] == BASE_ADDR[31:4])
      begin
         case (addr[3:0] - BASE_ADDR[3:0])
            `TICK_OFS_CTRL: s = SEL_CTRL;
            `TICK_OFS_RELOAD: s = SEL_RELOAD;
            `TICK_OFS_VALUE: s = SEL_VALUE;
            `TICK_OFS_CALIB: s = SEL_CALIB;
            default: s = SEL_NONE;
         endcase
      end
      return s;
   endfunction

   // Calibration word, fixed by hardware
   function automatic logic [31:0] calib_word();
      logic [31:0] w;
      w = 32'h00000000;
      w[`TICK_CALIB_NO_REFERENCE_CLOCK_FLAG_BIT] = `TICK_NO_REFERENCE_CLOCK_FLAG_VALUE;
      w[`TICK_CALIB_INEXACT_CALIBRATION_FLAG_BIT] = `TICK_INEXACT_CALIBRATION_FLAG_VALUE;
      w[`TICK_COUNT_MSB:0] = CALIB_COUNT;
      return w;
   endfunction

   // ==========================================================
   // APB handshake
   // One wait state: read data is sampled in the first access cycle, write data in the second
   assign sel = decode(paddr_in);
   assign bad_addr = (sel == SEL_NONE);
   assign access = psel_in & penable_in;
   assign capture = access & ~pready_reg;
   assign done = access & pready_reg;
   assign pready_next = capture;
   assign pslverr_next = capture ? bad_addr : 1'b0;

   assign wr_ctrl = done & pwrite_in & (sel == SEL_CTRL);
   assign wr_reload = done & pwrite_in & (sel == SEL_RELOAD);
   assign wr_value = done & pwrite_in & (sel == SEL_VALUE);
   assign rd_ctrl = done & ~pwrite_in & (sel == SEL_CTRL);

   // Read mux, reserved bits are zero
   always_comb
   begin
      prdata_next = 32'h00000000;
      if (capture && !pwrite_in)
      begin
         case (sel)
            SEL_CTRL:
            begin
               prdata_next[`TICK_CTRL_ENABLE_BIT] = enable_reg;
               prdata_next[`TICK_CTRL_TICK_INTERRUPT_ENABLE_BIT] = tick_interrupt_enable_reg;
               prdata_next[`TICK_CTRL_CLKSRC_BIT] = clksrc_reg;
               prdata_next[`TICK_CTRL_FLAG_BIT] = flag_reg;
            end
            SEL_RELOAD: prdata_next[`TICK_COUNT_MSB:0] = reload_reg;
            SEL_VALUE: prdata_next[`TICK_COUNT_MSB:0] = value_reg;
            SEL_CALIB: prdata_next = calib_word();
            default: prdata_next = 32'h00000000;
         endcase
      end
   end

   // Bus outputs
   always_ff @(posedge mclk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h00000000;
      end
      else
      begin
         pready_reg <= pready_next;
         pslverr_reg <= pslverr_next;
         if (capture)
            prdata_reg <= prdata_next;
      end
   end

   // ==========================================================
   // Control and reload registers
   // Only defined bits are stored, the rest is dropped
   always_ff @(posedge mclk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         enable_reg <= CTRL_RESET[`TICK_CTRL_ENABLE_BIT];
         tick_interrupt_enable_reg <= CTRL_RESET[`TICK_CTRL_TICK_INTERRUPT_ENABLE_BIT];
         clksrc_reg <= CTRL_RESET[`TICK_CTRL_CLKSRC_BIT];
         reload_reg <= `TICK_RELOAD_RESET;
      end
      else
      begin
         if (wr_ctrl)
         begin
            enable_reg <= pwdata_in[`TICK_CTRL_ENABLE_BIT];
            tick_interrupt_enable_reg <= pwdata_in[`TICK_CTRL_TICK_INTERRUPT_ENABLE_BIT];
            clksrc_reg <= pwdata_in[`TICK_CTRL_CLKSRC_BIT];
         end
         if (wr_reload)
            reload_reg <= pwdata_in[`TICK_COUNT_MSB:0];
      end
   end

   // ==========================================================
   // Count enable
   // Divider keeps running in debug halt, only clock gating or a clear enable_reg stops it
   assign ref_if.run = enable_reg & ~clock_stop_in;
   assign count_tick = enable_reg & ~clock_stop_in & ~debug_halt_in
      & (clksrc_reg | ref_if.ref_tick);
   assign reach_zero = count_tick & (value_reg == 24'h000001);

   tick_ref_divider #(
      .DIV(`TICK_REF_DIV)
   )
   u_divider (
      .mclk_in(mclk_in),
      .reset_n_in(reset_n_in),
      .ref_if(ref_if)
   );

   // ==========================================================
   // Down-counter
   // Zero reloads on the next tick, so reload 0 never fires
   always_comb
   begin
      value_next = value_reg;
      if (wr_value)
         value_next = 24'h000000;
      else if (count_tick)
      begin
         if (value_reg == 24'h000000)
            value_next = reload_reg;
         else
            value_next = value_reg - 24'h000001;
      end
   end

   always_ff @(posedge mclk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         value_reg <= `TICK_VALUE_RESET;
      else
         value_reg <= value_next;
   end

   // ==========================================================
   // Zero-reached flag
   // A new zero in the clearing cycle is kept: set beats clear
   always_comb
   begin
      flag_next = flag_reg;
      if (wr_value)
         flag_next = 1'b0;
      if (rd_ctrl && flag_returned_reg)
         flag_next = 1'b0;
      if (reach_zero)
         flag_next = 1'b1;
   end

   always_ff @(posedge mclk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         flag_reg <= CTRL_RESET[`TICK_CTRL_FLAG_BIT];
         flag_returned_reg <= 1'b0;
      end
      else
      begin
         flag_reg <= flag_next;
         if (capture)
            flag_returned_reg <= flag_reg & ~pwrite_in & (sel == SEL_CTRL);
      end
   end

   // Exception request, one cycle per zero
   always_ff @(posedge mclk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         request_reg <= 1'b0;
      else
         request_reg <= reach_zero & tick_interrupt_enable_reg;
   end

   // ==========================================================
   // Outputs
   assign prdata_out = prdata_reg;
   assign pready_out = pready_reg;
   assign pslverr_out = pslverr_reg;
   assign tick_request_out = request_reg;
   assign count_out = value_reg;

   // ==========================================================
   // Assertions
   a_value_read_live: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
      capture && !pwrite_in && sel == SEL_VALUE |=> prdata_out == {8'h00, $past(value_reg)})
      else $error("value read did not return the count");

   a_value_write_zeroes: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
      wr_value && !reach_zero |=> value_reg == 24'h000000 && !flag_reg)
      else $error("value write did not clear count and flag");

   a_calib_word_fixed: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
      done && !pwrite_in && sel == SEL_CALIB |-> prdata_out == {1'b0, 1'b1, 6'h00, CALIB_COUNT})
      else $error("calibration word wrong");

   a_hold_when_gated: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
      clock_stop_in && !wr_value |=> $stable(value_reg))
      else $error("counter moved while clock gated");

   a_hold_in_halt: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
      debug_halt_in && !wr_value |=> value_reg == $past(value_reg))
      else $error("counter moved during debug halt");

   a_count_step: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
      count_tick && !wr_value |=>
      value_reg == ($past(value_reg) == 24'h000000 ? $past(reload_reg) : $past(value_reg) - 24'h000001))
      else $error("count did not step or reload");

   a_zero_sets_flag: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
      reach_zero |=> flag_reg && value_reg == 24'h000000 && tick_request_out == $past(tick_interrupt_enable_reg))
      else $error("zero did not raise flag or request");

   a_flag_read_clears: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
      rd_ctrl && prdata_out[`TICK_CTRL_FLAG_BIT] && !reach_zero |=> !flag_reg)
      else $error("flag survived its read");

   a_reset_value_zero: assert property (@(posedge mclk_in)
      $rose(reset_n_in) |-> value_reg == 24'h000000)
      else $error("count not zero after reset");

   a_unmapped_error: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
      capture && bad_addr |=> pready_out && pslverr_out && prdata_out == 32'h00000000)
      else $error("unmapped access not refused");

   a_request_needs_zero: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
      tick_request_out |-> $past(reach_zero) && $past(tick_interrupt_enable_reg))
      else $error("request without zero or without its enable");

   a_ctrl_reserved_zero: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
      done && !pwrite_in && sel == SEL_CTRL |-> prdata_out[31:17] == 15'h0000 && prdata_out[15:3] == 13'h0000)
      else $error("control read shows reserved bits");

   a_word_reserved_zero: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
      done && !pwrite_in && (sel == SEL_RELOAD || sel == SEL_VALUE) |-> prdata_out[31:24] == 8'h00)
      else $error("reload or value read shows upper bits");

   a_ref_tick_spacing: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
      ref_if.ref_tick |=> !ref_if.ref_tick [*7])
      else $error("reference pulses closer than eight cycles");

   a_gate_stops_ref: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
      clock_stop_in |=> !ref_if.ref_tick)
      else $error("reference pulse while clock gated");

   a_pready_single: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
      pready_out |=> !pready_out)
      else $error("ready stood longer than one cycle");

   a_error_with_ready: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
      pslverr_out |-> pready_out)
      else $error("error shown without ready");
endmodule

// [shared/tick_defines.svh]
`ifndef TICK_DEFINES_SVH
`define TICK_DEFINES_SVH

// ==========================================================
// Register block placement
`define TICK_BASE_ADDR 32'he000e010
`define TICK_OFS_CTRL 4'h0
`define TICK_OFS_RELOAD 4'h4
`define TICK_OFS_VALUE 4'h8
`define TICK_OFS_CALIB 4'hc

// ==========================================================
// Field positions
`define TICK_CTRL_ENABLE_BIT 0
`define TICK_CTRL_TICK_INTERRUPT_ENABLE_BIT 1
`define TICK_CTRL_CLKSRC_BIT 2
`define TICK_CTRL_FLAG_BIT 16
`define TICK_CALIB_NO_REFERENCE_CLOCK_FLAG_BIT 31
`define TICK_CALIB_INEXACT_CALIBRATION_FLAG_BIT 30
`define TICK_COUNT_MSB 23

// ==========================================================
// Reset and fixed values
`define TICK_CTRL_RESET 32'h00000004
`define TICK_RELOAD_RESET 24'h000000
`define TICK_VALUE_RESET 24'h000000
`define TICK_CALIB_COUNT_RESET 24'h002328
`define TICK_NO_REFERENCE_CLOCK_FLAG_VALUE 1'b0
`define TICK_INEXACT_CALIBRATION_FLAG_VALUE 1'b1

// ==========================================================
// Reference clock divider
`define TICK_REF_DIV 8

`endif

// [shared/tick_pkg.sv]
package tick_pkg;
   // Register selected by a bus address
   typedef enum logic [2:0]
   {
      SEL_CTRL = 3'b000,
      SEL_RELOAD = 3'b001,
      SEL_VALUE = 3'b010,
      SEL_CALIB = 3'b011,
      SEL_NONE = 3'b100
   } reg_sel_type;

   // Live down-counter word
   typedef logic [23:0] count_type;
endpackage

// [shared/tick_ref_if.sv]
`timescale 1ns/1ps
// Link between the timer and its divide-by-8 reference
interface tick_ref_if;
   logic run;
   logic ref_tick;
   modport divider (input run, output ref_tick);
   modport timer (output run, input ref_tick);
endinterface

// [hdl/tick_ref_divider.sv]
`timescale 1ns/1ps
`include "tick_defines.svh"
module tick_ref_divider #(
   parameter int DIV = `TICK_REF_DIV
)
(
   input wire logic mclk_in, // Processor clock
   input wire logic reset_n_in, // Async reset, active low
   tick_ref_if.divider ref_if // Run request and reference pulse
);
   localparam int CW = $clog2(DIV);
   localparam logic [CW-1:0] LAST = CW'(DIV - 1);

   logic [CW-1:0] div_reg;
   logic tick_reg;

   // ==========================================================
   // Divider
   // Freezes with the gated clock so the phase survives sleep
   always_ff @(posedge mclk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         div_reg <= '0;
         tick_reg <= 1'b0;
      end
      else if (ref_if.run)
      begin
         tick_reg <= (div_reg == LAST);
         if (div_reg == LAST)
            div_reg <= '0;
         else
            div_reg <= div_reg + CW'(1);
      end
      else
         tick_reg <= 1'b0;
   end

   assign ref_if.ref_tick = tick_reg;
endmodule

// [testbench/system_tick_value_calib_tb_top.sv]
`timescale 1ns/1ps
`include "tick_defines.svh"
module system_tick_value_calib_tb_top;
   import tick_pkg::*;
   // ==========================================================
   // Register map and bench state
   localparam logic [31:0] A_CTRL = `TICK_BASE_ADDR + 32'h00000000;
   localparam logic [31:0] A_RELOAD = `TICK_BASE_ADDR + 32'h00000004;
   localparam logic [31:0] A_VALUE = `TICK_BASE_ADDR + 32'h00000008;
   localparam logic [31:0] A_CALIB = `TICK_BASE_ADDR + 32'h0000000c;
   logic mclk_in = 1'b0;
   logic reset_n_in = 1'b0;
   logic psel_in = 1'b0;
   logic penable_in = 1'b0;
   logic pwrite_in = 1'b0;
   logic [31:0] paddr_in = 32'h00000000;
   logic [31:0] pwdata_in = 32'h00000000;
   logic clock_stop_in = 1'b0;
   logic debug_halt_in = 1'b0;
   logic [31:0] prdata_out;
   logic pready_out;
   logic pslverr_out;
   logic tick_request_out;
   count_type count_out;
   int num_errors = 0;
   int check_count = 0;
   int pulses;

   system_tick_value_calib i_system_tick_value_calib (
      .mclk_in(mclk_in),
      .reset_n_in(reset_n_in),
      .psel_in(psel_in),
      .penable_in(penable_in),
      .pwrite_in(pwrite_in),
      .paddr_in(paddr_in),
      .pwdata_in(pwdata_in),
      .clock_stop_in(clock_stop_in),
      .debug_halt_in(debug_halt_in),
      .prdata_out(prdata_out),
      .pready_out(pready_out),
      .pslverr_out(pslverr_out),
      .tick_request_out(tick_request_out),
      .count_out(count_out)
   );

   // ==========================================================
   // Clock, 25 MHz
   initial
   begin
      forever #20 mclk_in = ~mclk_in;
   end

   // ==========================================================
   // Shared tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One APB transfer; ends one edge after release so the next setup never collides
   task automatic apb(input logic wr, input logic [31:0] addr, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      int n;
      n = 0;
      psel_in <= 1'b1;
      penable_in <= 1'b0;
      pwrite_in <= wr;
      paddr_in <= addr;
      pwdata_in <= wd;
      @(posedge mclk_in);
      penable_in <= 1'b1;
      do
      begin
         @(posedge mclk_in);
         n++;
      end
      while (pready_out !== 1'b1);
      rd = prdata_out;
      err = pslverr_out;
      // One wait state, so ready comes at the second access edge
      check(n, 32'd2);
      psel_in <= 1'b0;
      penable_in <= 1'b0;
      @(posedge mclk_in);
   endtask

   task automatic wr(input logic [31:0] addr, input logic [31:0] wd);
      logic [31:0] d;
      logic e;
      apb(1'b1, addr, wd, d, e);
      check({31'h0, e}, 32'h00000000);
   endtask

   task automatic rd_chk(input logic [31:0] addr, input logic [31:0] exp, input logic exp_err);
      logic [31:0] d;
      logic e;
      apb(1'b0, addr, 32'h00000000, d, e);
      check(d, exp);
      check({31'h0, e}, {31'h0, exp_err});
   endtask

   // Run counts, then show them; a hang reaches the same end
   task automatic print_verdict();
      $display("Checks %0d, errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // ==========================================================
   // Watchdog, far beyond the few hundred cycles the tests need
   initial
   begin
      #(5000 * 40);
      num_errors++;
      print_verdict();
   end

   // ==========================================================
   // Test sequence
   initial
   begin
      repeat (8) @(posedge mclk_in);
      reset_n_in <= 1'b1;
      @(posedge mclk_in);
      // Reset values and fixed calibration word
      rd_chk(A_VALUE, 32'h00000000, 1'b0);
      rd_chk(A_CTRL, 32'h00000004, 1'b0);
      rd_chk(A_CALIB, 32'h40002328, 1'b0);
      wr(A_CALIB, 32'h00000000);
      rd_chk(A_CALIB, 32'h40002328, 1'b0);
      // Reserved bits dropped, unmapped and misaligned refused
      wr(A_RELOAD, 32'hffffffff);
      rd_chk(A_RELOAD, 32'h00ffffff, 1'b0);
      wr(A_RELOAD, 32'h00000000);
      wr(A_CTRL, 32'hffffffff);
      rd_chk(A_CTRL, 32'h00000007, 1'b0);
      rd_chk(`TICK_BASE_ADDR + 32'h00000010, 32'h00000000, 1'b1);
      rd_chk(`TICK_BASE_ADDR + 32'h00000002, 32'h00000000, 1'b1);
      // Reload 3 gives one request every 4 cycles
      wr(A_RELOAD, 32'h00000003);
      repeat (20) @(posedge mclk_in);
      pulses = 0;
      repeat (16)
      begin
         @(posedge mclk_in);
         if (tick_request_out === 1'b1)
            pulses++;
      end
      check(pulses, 32'd4);
      pulses = 0;
      while (count_out !== 24'h000000 && pulses < 10)
      begin
         @(posedge mclk_in);
         pulses++;
      end
      @(posedge mclk_in);
      check({8'h00, count_out}, 32'h00000003);
      debug_halt_in <= 1'b1;
      @(posedge mclk_in);
      // Flag reads once, then clears
      rd_chk(A_CTRL, 32'h00010007, 1'b0);
      rd_chk(A_CTRL, 32'h00000007, 1'b0);
      wr(A_RELOAD, 32'h00000001);
      debug_halt_in <= 1'b0;
      repeat (4) @(posedge mclk_in);
      debug_halt_in <= 1'b1;
      @(posedge mclk_in);
      // Upper bits kept zero by software; write clears count and flag
      wr(A_VALUE, 32'h00abcdef);
      rd_chk(A_VALUE, 32'h00000000, 1'b0);
      rd_chk(A_CTRL, 32'h00000007, 1'b0);
      // Five ticks: load 0x100, then four decrements
      wr(A_RELOAD, 32'h00000100);
      debug_halt_in <= 1'b0;
      repeat (5) @(posedge mclk_in);
      debug_halt_in <= 1'b1;
      repeat (6) @(posedge mclk_in);
      rd_chk(A_VALUE, 32'h000000fc, 1'b0);
      // Divide-by-8 source: 16 cycles hold exactly two ticks
      wr(A_CTRL, 32'h00000001);
      wr(A_VALUE, 32'h00000000);
      debug_halt_in <= 1'b0;
      repeat (16) @(posedge mclk_in);
      debug_halt_in <= 1'b1;
      @(posedge mclk_in);
      rd_chk(A_VALUE, 32'h000000ff, 1'b0);
      // Gated clock freezes the count even with halt released
      clock_stop_in <= 1'b1;
      debug_halt_in <= 1'b0;
      repeat (10) @(posedge mclk_in);
      rd_chk(A_VALUE, 32'h000000ff, 1'b0);
      rd_chk(A_CTRL, 32'h00000001, 1'b0);
      // Request stays low without its enable, flag still sets
      clock_stop_in <= 1'b0;
      wr(A_RELOAD, 32'h00000003);
      wr(A_VALUE, 32'h00000000);
      wr(A_CTRL, 32'h00000005);
      pulses = 0;
      repeat (16)
      begin
         @(posedge mclk_in);
         if (tick_request_out === 1'b1)
            pulses++;
      end
      check(pulses, 32'd0);
      rd_chk(A_CTRL, 32'h00010005, 1'b0);
      // Mid-run reset while counting
      reset_n_in <= 1'b0;
      repeat (2) @(posedge mclk_in);
      reset_n_in <= 1'b1;
      @(posedge mclk_in);
      rd_chk(A_VALUE, 32'h00000000, 1'b0);
      rd_chk(A_CTRL, 32'h00000004, 1'b0);
      print_verdict();
   end
endmodule
